// >>> hst_chan.sv
// one 32-bit timer/counter channel with preset and current value
// assumes step pulses arrive as one-cycle enables on the system clock
`timescale 1ns/1ns
module hst_chan
	import hst_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_step,
	input wire logic i_restart,
	input wire logic i_wr_cur,
	input wire logic i_wr_pre,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_cur,
	output logic [31:0] o_pre,
	output logic o_hit
);
	logic [31:0] cur_ff;
	logic [31:0] pre_ff;
	logic [31:0] nxt_cur;
	logic hit;

	// a zero preset never hits, so the channel free-runs and wraps
	assign hit = i_step && (pre_ff != PRE_RST) && ((cur_ff + 32'h1) == pre_ff);

	always_comb begin
		nxt_cur = cur_ff;
		// R7 zero restarts
		if (i_wr_cur) begin
			nxt_cur = i_wdata;
		end else if (hit && i_restart) begin
			// R16 restart after hit
			nxt_cur = CUR_RST;
		end else if (i_step) begin
			// R6 wrap at max
			nxt_cur = cur_ff + 32'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur_ff <= CUR_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pre_ff <= PRE_RST;
		end else if (i_wr_pre) begin
			pre_ff <= i_wdata;
		end
	end

	// host write to the current value wins over a hit in the same cycle
	assign o_hit = hit && !i_wr_cur;
	assign o_cur = cur_ff;
	assign o_pre = pre_ff;
endmodule

// >>> hst_host.sv
// host model issuing accesses and interrupt commands
// assumes requests are taken at the rising edge after they are raised
`timescale 1ns/1ns
module hst_host (
	input wire logic i_clk,
	input wire logic [31:0] i_rdata,
	input wire logic i_rvalid,
	input wire logic i_acc_err,
	output logic o_acc_valid,
	output logic o_acc_write,
	output logic [2:0] o_channel_select,
	output logic o_target_select,
	output logic [31:0] o_wdata,
	output logic o_irq_cmd_valid,
	output logic o_irq_cmd_enable,
	output logic [2:0] o_irq_channel
);
	logic [31:0] rd;
	logic er;
	logic rv;
	initial {o_acc_valid, o_acc_write, o_channel_select, o_target_select,
		o_wdata, o_irq_cmd_valid, o_irq_cmd_enable, o_irq_channel} = '0;
	task automatic acc(input logic w, input logic [2:0] c, input logic t,
		input logic [31:0] d);
		@(posedge i_clk);
		{o_acc_valid, o_acc_write, o_channel_select, o_target_select,
			o_wdata} <= {1'h1, w, c, t, d};
		@(posedge i_clk);
		o_acc_valid <= 1'h0;
		#1;
		rd = i_rdata;
		er = i_acc_err;
		rv = i_rvalid;
	endtask
	task automatic cmd(input logic e, input logic [2:0] c);
		@(posedge i_clk);
		{o_irq_cmd_valid, o_irq_cmd_enable, o_irq_channel} <= {1'h1, e, c};
		@(posedge i_clk);
		o_irq_cmd_valid <= 1'h0;
		#1;
	endtask
endmodule

// >>> hst_pkg.sv
// constants shared by the timer bank and its channel module
// assumes a single 50 MHz clock and a host that drives plain access ports
package hst_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	// tick period in nanoseconds
	localparam int unsigned TICK_NS = 100000;
	// prescaler count for one tick, rounded down, at least one cycle
	localparam int unsigned TICK_CYCLES_DEF = (TICK_NS / (1000000000 / CLK_HZ)) < 1
		? 1 : (TICK_NS / (1000000000 / CLK_HZ));
	localparam int unsigned NUM_CHAN = 5;
	localparam int unsigned NUM_CNT = 4;
	localparam int unsigned VAL_W = 32;
	localparam int unsigned AUX_PRE_W = 16;
	localparam logic [2:0] CHAN_AUX = 3'h4;
	localparam logic [2:0] CHAN_LAST_CNT = 3'h3;
	localparam logic TARGET_PRESET = 1'h1;
	localparam logic TARGET_CURRENT = 1'h0;
	localparam logic [31:0] AUX_PRE_MIN = 32'h00000002;
	localparam logic [31:0] AUX_PRE_ONE = 32'h00000001;
	localparam logic [31:0] CUR_RST = 32'h00000000;
	localparam logic [31:0] PRE_RST = 32'h00000000;
	localparam logic [4:0] IRQ_EN_RST = 5'h1F;
endpackage

// >>> hst_props.sv
// port checker for the timer bank
// assumes the bank is built with TICK_CYCLES of 4
`timescale 1ns/1ns
module hst_props
	import hst_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 4
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_acc_valid,
	input wire logic i_acc_write,
	input wire logic [2:0] i_channel_select,
	input wire logic i_irq_cmd_valid,
	input wire logic i_irq_cmd_enable,
	input wire logic [2:0] i_irq_channel,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_acc_err,
	input wire logic [4:0] o_timer_irq,
	input wire logic [4:0] o_irq_enable,
	input wire logic o_tick
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic rd_ok;
	logic bad;
	assign rd_ok = i_acc_valid && !i_acc_write && i_channel_select <= CHAN_AUX;
	assign bad = i_acc_valid && i_channel_select > CHAN_AUX;
	// spacing fixed at four cycles, the simulation setting
	a_tick_period: assert property (o_tick |=> !o_tick [*3] ##1 o_tick)
		else $error("tick spacing wrong");
	a_read_answer: assert property (rd_ok |=> o_rvalid && !o_acc_err)
		else $error("read not answered");
	a_no_rvalid: assert property (!(i_acc_valid && !i_acc_write) |=> !o_rvalid)
		else $error("read data without read");
	a_bad_refused: assert property (bad |=> o_acc_err)
		else $error("bad channel not refused");
	a_err_cause: assert property (!bad |=> !o_acc_err)
		else $error("error without cause");
	a_bad_read_zero: assert property (bad && !i_acc_write |=> o_rdata == 32'h00000000)
		else $error("refused read returned data");
	a_irq_cmd: assert property (i_irq_cmd_valid && i_irq_channel <= CHAN_AUX |=>
		o_irq_enable[$past(i_irq_channel)] == $past(i_irq_cmd_enable))
		else $error("enable command lost");
	a_irq_masked: assert property
		((o_timer_irq & ~o_irq_enable & ~$past(o_irq_enable)) == 5'h0)
		else $error("masked interrupt delivered");
	a_aux_on_tick: assert property (o_timer_irq[4] |-> o_tick)
		else $error("aux interrupt off tick");
	c_aux_irq: cover property (o_timer_irq[4]);
	c_cnt_irq: cover property (o_timer_irq[3]);
	c_bad: cover property (o_acc_err);
endmodule
bind hst_timer_bank hst_props #(.TICK_CYCLES(TICK_CYCLES)) i_props (
	.i_clk(i_clk),
	.i_reset_n(i_reset_n),
	.i_acc_valid(i_acc_valid),
	.i_acc_write(i_acc_write),
	.i_channel_select(i_channel_select),
	.i_irq_cmd_valid(i_irq_cmd_valid),
	.i_irq_cmd_enable(i_irq_cmd_enable),
	.i_irq_channel(i_irq_channel),
	.o_rdata(o_rdata),
	.o_rvalid(o_rvalid),
	.o_acc_err(o_acc_err),
	.o_timer_irq(o_timer_irq),
	.o_irq_enable(o_irq_enable),
	.o_tick(o_tick)
);

// >>> hst_timer_bank.sv
// bank of one auxiliary timer and four counter/timer channels
// assumes synchronous host access ports and synchronous counting inputs
//
// Contract
// R1: channel select 4 is the auxiliary timer, 0 to 3 the counter channels
// R2: target select 1 writes the selected channel's preset value
// R3: target select 0 writes or reads the selected current value
// R4: delay timer interrupts once every preset times 0.1 ms
// R5: periodic interrupt keeps recurring while the timer is enabled
// R6: cyclic mode counts up every 0.1 ms from zero and wraps
// R7: writing zero to the current value restarts timing from zero
// R8: host reads the live count without disturbing counting
// R9: each counter channel is a pulse counter or a timer per config
// R10: auxiliary timer is always a timer; counter channels only when set
// R11: each channel's interrupt is enabled or disabled by host command
// R12: single up count mode counts rising edges on the up input only
// R13: counting inputs are non-inverted
// R14: aux delays with preset of 2 or more, free-runs without irq at 0
// R15: channels are 32 bits; aux delay preset limited to 0002H..FFFFH
// R16: after each delay interrupt the count restarts from zero
// R17: one shared prescaler derives the 0.1 ms tick from the clock
`timescale 1ns/1ns
module hst_timer_bank
	import hst_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_acc_valid,
	input wire logic i_acc_write,
	input wire logic [2:0] i_channel_select,
	input wire logic i_target_select,
	input wire logic [31:0] i_wdata,
	input wire logic i_irq_cmd_valid,
	input wire logic i_irq_cmd_enable,
	input wire logic [2:0] i_irq_channel,
	input wire logic [3:0] i_chan_is_timer,
	input wire logic [3:0] i_chan_up_in,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output logic o_acc_err,
	output logic [4:0] o_timer_irq,
	output logic [4:0] o_irq_enable,
	output logic o_tick
);
	localparam int unsigned PRESC_W = $clog2(TICK_CYCLES + 1);

	logic [PRESC_W-1:0] presc_ff;
	logic tick;
	logic [3:0] up_prev_ff;
	logic [4:0] step;
	logic [4:0] restart;
	logic [4:0] wr_cur;
	logic [4:0] wr_pre;
	logic [4:0] hit;
	logic [31:0] cur [NUM_CHAN];
	logic [31:0] pre [NUM_CHAN];
	logic chan_ok;
	logic [31:0] wdata_eff;
	logic [31:0] rd_sel;
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic acc_err_ff;
	logic [4:0] irq_ff;
	logic [4:0] irq_en_ff;
	logic tick_ff;

	// one divider for all channels keeps their ticks in step
	// R17 shared prescaler
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			presc_ff <= '0;
		end else if (presc_ff == PRESC_W'(TICK_CYCLES - 1)) begin
			presc_ff <= '0;
		end else begin
			presc_ff <= presc_ff + PRESC_W'(1);
		end
	end

	assign tick = (presc_ff == PRESC_W'(TICK_CYCLES - 1));

	// cleared to the idle level of the pins, so no false edge after reset
	// R12 edge history of up inputs
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			up_prev_ff <= 4'h0;
		end else begin
			up_prev_ff <= i_chan_up_in;
		end
	end

	// R1 channel decode
	assign chan_ok = (i_channel_select <= CHAN_AUX);

	// a preset of one would hit on every tick, so it is raised to two
	// R15 aux preset limited to 16 bits, never below two unless zero
	always_comb begin
		wdata_eff = i_wdata;
		if (i_channel_select == CHAN_AUX && i_target_select == TARGET_PRESET) begin
			wdata_eff = {16'h0000, i_wdata[AUX_PRE_W-1:0]};
			if (wdata_eff == AUX_PRE_ONE) begin
				wdata_eff = AUX_PRE_MIN;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_chan
			if (g == NUM_CHAN - 1) begin : g_aux
				// R10 aux always timer
				assign step[g] = tick;
				// R14 aux restarts as delay timer
				assign restart[g] = 1'b1;
			end else begin : g_cnt
				// R9 timer or counter
				// R13 non-inverted, R12 rising up edges only
				assign step[g] = i_chan_is_timer[g] ? tick
					: (i_chan_up_in[g] && !up_prev_ff[g]);
				// R16 timer channels restart on hit
				assign restart[g] = i_chan_is_timer[g];
			end
			// R2 preset write
			assign wr_pre[g] = i_acc_valid && i_acc_write
				&& (i_channel_select == 3'(g))
				&& (i_target_select == TARGET_PRESET);
			// R3 current write
			assign wr_cur[g] = i_acc_valid && i_acc_write
				&& (i_channel_select == 3'(g))
				&& (i_target_select == TARGET_CURRENT);
			// R6 R7 counting, wrap and reload live in the channel
			hst_chan u_chan (
				.i_clk(i_clk),
				.i_reset_n(i_reset_n),
				.i_step(step[g]),
				.i_restart(restart[g]),
				.i_wr_cur(wr_cur[g]),
				.i_wr_pre(wr_pre[g]),
				.i_wdata(wdata_eff),
				.o_cur(cur[g]),
				.o_pre(pre[g]),
				.o_hit(hit[g])
			);
		end
	endgenerate

	// constant indices only, so codes 5 to 7 never index past the array
	// R8 read selection
	always_comb begin
		rd_sel = 32'h00000000;
		for (int k = 0; k < NUM_CHAN; k++) begin
			if (i_channel_select == 3'(k)) begin
				if (i_target_select == TARGET_PRESET) begin
					rd_sel = pre[k];
				end else begin
					rd_sel = cur[k];
				end
			end
		end
	end

	// R8 live read without side effects
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_ff <= 32'h00000000;
		end else if (i_acc_valid && !i_acc_write) begin
			rdata_ff <= rd_sel;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= i_acc_valid && !i_acc_write;
		end
	end

	// R1 codes 5 to 7 are refused
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			acc_err_ff <= 1'b0;
		end else begin
			acc_err_ff <= i_acc_valid && !chan_ok;
		end
	end

	// R11 per-channel enable command
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_en_ff <= IRQ_EN_RST;
		end else if (i_irq_cmd_valid && i_irq_channel <= CHAN_AUX) begin
			irq_en_ff[i_irq_channel] <= i_irq_cmd_enable;
		end
	end

	// registered so an aux pulse coincides with the tick output
	// R4 R5 gated periodic pulse
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_ff <= 5'h00;
		end else begin
			irq_ff <= hit & irq_en_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= tick;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_rvalid = rvalid_ff;
	assign o_acc_err = acc_err_ff;
	assign o_timer_irq = irq_ff;
	assign o_irq_enable = irq_en_ff;
	assign o_tick = tick_ff;
endmodule

// >>> tb_hs_periodic_timer_bank.sv
// self-checking bench for the timer bank
// assumes a prescaler of 4 cycles so ticks come quickly
`timescale 1ns/1ns
module tb_hs_periodic_timer_bank;
	import hst_pkg::*;
	logic i_clk = 1'h0, i_reset_n = 1'h0, i_acc_valid, i_acc_write;
	logic i_target_select, i_irq_cmd_valid, i_irq_cmd_enable, o_rvalid;
	logic o_acc_err, o_tick;
	logic [2:0] i_channel_select, i_irq_channel;
	logic [3:0] i_chan_is_timer = 4'h7, i_chan_up_in = 4'h0;
	logic [31:0] i_wdata, o_rdata;
	logic [4:0] o_timer_irq, o_irq_enable;
	int bad_count = 0, compares = 0, n;
	hst_timer_bank #(.TICK_CYCLES(4)) i_dut (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_acc_valid(i_acc_valid),
		.i_acc_write(i_acc_write),
		.i_channel_select(i_channel_select),
		.i_target_select(i_target_select),
		.i_wdata(i_wdata),
		.i_irq_cmd_valid(i_irq_cmd_valid),
		.i_irq_cmd_enable(i_irq_cmd_enable),
		.i_irq_channel(i_irq_channel),
		.i_chan_is_timer(i_chan_is_timer),
		.i_chan_up_in(i_chan_up_in),
		.o_rdata(o_rdata),
		.o_rvalid(o_rvalid),
		.o_acc_err(o_acc_err),
		.o_timer_irq(o_timer_irq),
		.o_irq_enable(o_irq_enable),
		.o_tick(o_tick)
	);
	hst_host i_host (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
		.i_acc_err(o_acc_err), .o_acc_valid(i_acc_valid),
		.o_acc_write(i_acc_write), .o_channel_select(i_channel_select),
		.o_target_select(i_target_select), .o_wdata(i_wdata),
		.o_irq_cmd_valid(i_irq_cmd_valid), .o_irq_cmd_enable(i_irq_cmd_enable),
		.o_irq_channel(i_irq_channel));
	initial forever #10 i_clk = ~i_clk;
	task automatic chk(input logic ok, input string m);
		compares++;
		if (!ok) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// a found pulse ends the wait; n equal to lim means none came before the last cycle
	task automatic wirq(input int i, input int lim);
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (n < lim && o_timer_irq[i] !== 1'h1);
	endtask
	task automatic s_aux();
		i_host.acc(1, CHAN_AUX, TARGET_PRESET, 32'h1);
		i_host.acc(0, CHAN_AUX, TARGET_PRESET, 32'h0);
		chk(i_host.rd === 32'h2, "aux preset floor");
		i_host.acc(1, CHAN_AUX, TARGET_PRESET, 32'h00010005);
		i_host.acc(1, CHAN_AUX, TARGET_CURRENT, 32'h0);
		wirq(4, 40);
		wirq(4, 40);
		chk(n == 20, "aux period");
		chk(o_tick === 1'h1, "tick with aux irq");
	endtask
	task automatic s_cyc();
		i_host.acc(1, 3'h0, TARGET_CURRENT, 32'hFFFFFFFF);
		repeat (3) @(posedge i_clk);
		i_host.acc(0, 3'h0, TARGET_CURRENT, 32'h0);
		chk(i_host.rd === 32'h0, "wrap");
		repeat (6) @(posedge i_clk);
		i_host.acc(0, 3'h0, TARGET_CURRENT, 32'h0);
		chk(i_host.rd === 32'h2 && i_host.rv === 1'h1, "live count");
	endtask
	task automatic s_mask();
		i_host.cmd(0, 3'h2);
		chk(o_irq_enable === 5'h1B, "disable");
		i_host.acc(1, 3'h2, TARGET_PRESET, 32'h3);
		// the channel has counted far past three since reset
		i_host.acc(1, 3'h2, TARGET_CURRENT, 32'h0);
		wirq(2, 40);
		chk(n == 40, "masked irq");
		i_host.cmd(1, 3'h2);
		wirq(2, 20);
		chk(n < 14, "timer channel irq");
		wirq(2, 20);
		chk(n == 12, "timer channel period");
	endtask
	task automatic s_cnt();
		i_host.acc(1, 3'h3, TARGET_PRESET, 32'h3);
		repeat (3) begin
			@(posedge i_clk) i_chan_up_in <= 4'h8;
			@(posedge i_clk) i_chan_up_in <= 4'h0;
		end
		// the third up edge is taken at the last edge of the loop
		#1;
		chk(o_timer_irq[3] === 1'h1, "counter irq");
		wirq(3, 5);
		chk(n == 5, "counter irq once");
		i_host.acc(0, 3'h3, TARGET_CURRENT, 32'h0);
		chk(i_host.rd === 32'h3, "pulse count");
		i_host.acc(0, 3'h6, TARGET_CURRENT, 32'h0);
		chk(i_host.er === 1'h1 && i_host.rd === 32'h0, "bad channel");
	endtask
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#1000000;
		bad_count++;
		summarize();
	end
	initial begin
		repeat (4) @(posedge i_clk);
		chk(o_irq_enable === 5'h1F && o_timer_irq === 5'h0
			&& o_rvalid === 1'h0 && o_acc_err === 1'h0 && o_tick === 1'h0
			&& o_rdata === 32'h0, "reset");
		i_reset_n <= 1'h1;
		s_aux();
		s_cyc();
		s_mask();
		s_cnt();
		summarize();
	end
endmodule
